/* File: include/umam_pkg.sv */
`default_nettype none
package umam_pkg;
    // Register map of the device end, byte addresses on its own port
    localparam logic [7:0] UMAM_SLAVE_ADDR_OFS = 8'ha9;
    localparam logic [7:0] UMAM_SLAVE_MASK_OFS = 8'hb9;
    localparam logic [7:0] UMAM_ADDR_RESET = 8'h00;
    // Controller registers on Wishbone, word offsets as byte addresses
    localparam logic [7:0] UMAM_WB_CTRL_OFS = 8'h00;
    localparam logic [7:0] UMAM_WB_STAT_OFS = 8'h04;
    localparam logic [7:0] UMAM_WB_MASK_OFS = 8'h08;
    localparam logic [7:0] UMAM_WB_RXDATA_OFS = 8'h0c;
    localparam logic [7:0] UMAM_WB_SLV_ADDR_OFS = 8'h10;
    localparam logic [7:0] UMAM_WB_SMASK_OFS = 8'h14;
    // Control bits
    localparam int UMAM_CTRL_REN_BIT = 0;
    localparam int UMAM_CTRL_FILT_BIT = 1;
    localparam int UMAM_CTRL_TEN_BIT = 2;
    // Status and interrupt bits
    localparam int UMAM_IRQ_RX_BIT = 0;
    localparam int UMAM_IRQ_LOST_BIT = 1;
    localparam int UMAM_IRQ_W = 2;
    localparam logic [2:0] UMAM_CTRL_RESET = 3'h1;
    localparam logic [UMAM_IRQ_W-1:0] UMAM_IRQ_RESET = 2'h0;
endpackage
`default_nettype wire

/* File: include/umam_if.sv */
`timescale 1ns/1ns
`default_nettype none
// One frame moves per cycle of frame_valid; frame_ninth is the ninth or the stop bit
interface umam_if;
    logic frame_valid;
    logic [7:0] frame_data;
    logic frame_ninth;
    logic ten_bit_mode;
    logic reg_wr;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic rx_done_flag;
    logic rx_done_clr;
    logic [7:0] serial_buffer;
    logic rx_ninth_bit;
    modport device (
        input frame_valid, frame_data, frame_ninth, ten_bit_mode,
        input reg_wr, reg_addr, reg_wdata, rx_done_clr,
        output reg_rdata, rx_done_flag, serial_buffer, rx_ninth_bit
    );
    modport ctrl (
        output frame_valid, frame_data, frame_ninth, ten_bit_mode,
        output reg_wr, reg_addr, reg_wdata, rx_done_clr,
        input reg_rdata, rx_done_flag, serial_buffer, rx_ninth_bit
    );
endinterface
`default_nettype wire

/* File: hw/umam_match.sv */
`timescale 1ns/1ns
`default_nettype none
module umam_match
    import umam_pkg::*;
#(
    parameter int W = 8
) (
    // Address pair and candidate byte
    input wire logic [W-1:0] slave_addr_in,
    input wire logic [W-1:0] slave_mask_in,
    input wire logic [W-1:0] byte_in,
    // Verdict
    output logic match_out
);
    logic [W-1:0] bcast;
    logic given_hit;
    logic bcast_hit;
    assign bcast = slave_addr_in | slave_mask_in; // [R6]
    assign given_hit = ((byte_in ^ slave_addr_in) & slave_mask_in) == '0; // [R5] [R12]
    assign bcast_hit = (bcast & ~byte_in) == '0; // [R12]
    assign match_out = given_hit | bcast_hit;
endmodule // umam_match
`default_nettype wire

/* File: hw/umam_device.sv */
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// [R1] Ninth bit high marks address, low data
// [R2] Filtering on: flag only on matching address
// [R3] Filtering off: flag on every frame
// [R4] Ten-bit mode: stop bit acts as ninth
// [R5] Given address: mask-selected slave address bits
// [R6] Broadcast is OR of address and mask
// [R7] Address registers at A9h and B9h
// [R8] Both address registers reset to zero
// [R9] Software keeps filtering on awaiting address
// [R10] Addressed slave turns filtering off afterwards
// [R11] Master sends address before data bytes
// [R12] Match: masked equality or broadcast ones
// [R13] Load only if flag clear and allowed
// [R14] Store ninth bit beside the data byte
// [R15] Frames ignored while receive disabled
module umam_device
    import umam_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic ARST_N_IN,
    // Link and register port
    umam_if.device LINK,
    // Control
    input wire logic RX_ENABLE_IN,
    input wire logic ADDR_FILTER_EN_IN,
    // Status
    output logic FRAME_DROP_OUT
);
    typedef struct packed {
        logic [7:0] slave_addr_reg;
        logic [7:0] slave_addr_mask;
        logic [7:0] serial_buffer;
        logic rx_ninth_bit;
        logic rx_done_flag;
        logic drop;
    } umam_dev_state_t;
    umam_dev_state_t s_reg, s_next;
    logic hit;
    logic accept;
    umam_match #(.W(8)) u_match (
        .slave_addr_in(s_reg.slave_addr_reg),
        .slave_mask_in(s_reg.slave_addr_mask),
        .byte_in(LINK.frame_data),
        .match_out(hit)
    );
    // Nine-bit and ten-bit modes share one test: frame_ninth is the ninth or stop bit
    always_comb begin
        accept = !ADDR_FILTER_EN_IN || (LINK.frame_ninth && hit); // [R1] [R2] [R3] [R4]
        s_next = s_reg;
        s_next.drop = 1'b0;
        if (LINK.reg_wr) begin
            if (LINK.reg_addr == UMAM_SLAVE_ADDR_OFS) begin // [R7]
                s_next.slave_addr_reg = LINK.reg_wdata;
            end
            if (LINK.reg_addr == UMAM_SLAVE_MASK_OFS) begin // [R7]
                s_next.slave_addr_mask = LINK.reg_wdata;
            end
        end
        if (LINK.rx_done_clr) begin
            s_next.rx_done_flag = 1'b0;
        end
        if (RX_ENABLE_IN && LINK.frame_valid && accept) begin // [R15]
            if (!s_reg.rx_done_flag) begin // [R13]
                s_next.serial_buffer = LINK.frame_data;
                s_next.rx_ninth_bit = LINK.frame_ninth; // [R14]
                s_next.rx_done_flag = 1'b1;
            end else begin
                // Flag still up: the frame is lost, as in the original receiver
                s_next.drop = 1'b1;
            end
        end
    end
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            s_reg <= '{UMAM_ADDR_RESET, UMAM_ADDR_RESET, 8'h00, 1'b0, 1'b0, 1'b0}; // [R8]
        end else begin
            s_reg <= s_next;
        end
    end
    always_comb begin
        if (LINK.reg_addr == UMAM_SLAVE_ADDR_OFS) begin
            LINK.reg_rdata = s_reg.slave_addr_reg;
        end else if (LINK.reg_addr == UMAM_SLAVE_MASK_OFS) begin
            LINK.reg_rdata = s_reg.slave_addr_mask;
        end else begin
            LINK.reg_rdata = 8'h00;
        end
    end
    assign LINK.rx_done_flag = s_reg.rx_done_flag;
    assign LINK.serial_buffer = s_reg.serial_buffer;
    assign LINK.rx_ninth_bit = s_reg.rx_ninth_bit;
    assign FRAME_DROP_OUT = s_reg.drop;
endmodule // umam_device
`default_nettype wire

/* File: hw/umam_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module umam_ctrl
    import umam_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic ARST_N_IN,
    // Wishbone slave
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    // Frame source from the serial front end
    input wire logic FRAME_VALID_IN,
    input wire logic [7:0] FRAME_DATA_IN,
    input wire logic FRAME_NINTH_IN,
    // Interrupt and device control
    output logic IRQ_OUT,
    output logic RX_ENABLE_OUT,
    output logic ADDR_FILTER_EN_OUT,
    // Link to the device end
    umam_if.ctrl LINK
);
    typedef struct packed {
        logic [2:0] ctrl;
        logic [UMAM_IRQ_W-1:0] stat;
        logic [UMAM_IRQ_W-1:0] mask;
        logic [31:0] rdata;
        logic ack;
        logic done_q;
    } umam_ctl_state_t;
    umam_ctl_state_t s_reg, s_next;
    logic req;
    logic [31:0] rd;
    logic rx_rise;
    assign req = WB_CYC_IN && WB_STB_IN && !s_reg.ack;
    assign rx_rise = LINK.rx_done_flag && !s_reg.done_q;
    always_comb begin
        unique case (WB_ADR_IN)
            UMAM_WB_CTRL_OFS: rd = {29'h0, s_reg.ctrl};
            UMAM_WB_STAT_OFS: rd = {30'h0, s_reg.stat};
            UMAM_WB_MASK_OFS: rd = {30'h0, s_reg.mask};
            UMAM_WB_RXDATA_OFS: rd = {22'h0, LINK.rx_done_flag, LINK.rx_ninth_bit,
                                      LINK.serial_buffer};
            UMAM_WB_SLV_ADDR_OFS, UMAM_WB_SMASK_OFS: rd = {24'h0, LINK.reg_rdata};
            default: rd = 32'h0;
        endcase
    end
    always_comb begin
        s_next = s_reg;
        s_next.ack = req;
        s_next.done_q = LINK.rx_done_flag;
        if (req && !WB_WE_IN) begin
            s_next.rdata = rd;
        end
        if (req && WB_WE_IN && WB_SEL_IN[0]) begin
            if (WB_ADR_IN == UMAM_WB_CTRL_OFS) begin
                s_next.ctrl = WB_DAT_IN[2:0];
            end
            if (WB_ADR_IN == UMAM_WB_MASK_OFS) begin
                s_next.mask = WB_DAT_IN[UMAM_IRQ_W-1:0];
            end
            if (WB_ADR_IN == UMAM_WB_STAT_OFS) begin
                s_next.stat = s_reg.stat & ~WB_DAT_IN[UMAM_IRQ_W-1:0];
            end
        end
        // Set wins over a clear in the same cycle
        if (rx_rise) begin
            s_next.stat[UMAM_IRQ_RX_BIT] = 1'b1;
        end
        if (FRAME_VALID_IN && LINK.rx_done_flag) begin
            s_next.stat[UMAM_IRQ_LOST_BIT] = 1'b1;
        end
    end
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            s_reg <= '{UMAM_CTRL_RESET, UMAM_IRQ_RESET, UMAM_IRQ_RESET, 32'h0, 1'b0, 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end
    // Pass-through of address-register writes to the device's own port
    assign LINK.reg_wr = req && WB_WE_IN && WB_SEL_IN[0] &&
                         (WB_ADR_IN == UMAM_WB_SLV_ADDR_OFS || WB_ADR_IN == UMAM_WB_SMASK_OFS);
    assign LINK.reg_addr = (WB_ADR_IN == UMAM_WB_SMASK_OFS) ? UMAM_SLAVE_MASK_OFS
                                                            : UMAM_SLAVE_ADDR_OFS;
    assign LINK.reg_wdata = WB_DAT_IN[7:0];
    // Reading received data hands the buffer back to the receiver
    assign LINK.rx_done_clr = req && !WB_WE_IN && (WB_ADR_IN == UMAM_WB_RXDATA_OFS);
    assign LINK.frame_valid = FRAME_VALID_IN;
    assign LINK.frame_data = FRAME_DATA_IN;
    assign LINK.frame_ninth = FRAME_NINTH_IN; // [R1] [R11]
    assign LINK.ten_bit_mode = s_reg.ctrl[UMAM_CTRL_TEN_BIT];
    assign RX_ENABLE_OUT = s_reg.ctrl[UMAM_CTRL_REN_BIT];
    assign ADDR_FILTER_EN_OUT = s_reg.ctrl[UMAM_CTRL_FILT_BIT]; // [R9] [R10]
    assign WB_ACK_OUT = s_reg.ack;
    assign WB_DAT_OUT = s_reg.rdata;
    assign IRQ_OUT = |(s_reg.stat & s_reg.mask);
endmodule // umam_ctrl
`default_nettype wire

/* File: test/umam_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module umam_chk (
    // Clock, reset and control levels
    input wire logic CORE_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic RX_ENABLE_IN,
    input wire logic ADDR_FILTER_EN_IN,
    // Link signals
    input wire logic frame_valid,
    input wire logic [7:0] frame_data,
    input wire logic frame_ninth,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic rx_done_flag,
    input wire logic rx_done_clr,
    input wire logic [7:0] serial_buffer,
    input wire logic rx_ninth_bit
);
    logic [7:0] addr_reg;
    logic [7:0] mask_reg;
    logic given;
    logic bcast;
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    // Mirror of the two address registers
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            addr_reg <= 8'h00;
            mask_reg <= 8'h00;
        end else if (reg_wr && reg_addr == 8'ha9) begin
            addr_reg <= reg_wdata;
        end else if (reg_wr && reg_addr == 8'hb9) begin
            mask_reg <= reg_wdata;
        end
    end
    assign given = ((frame_data ^ addr_reg) & mask_reg) == 8'h00;
    assign bcast = ((addr_reg | mask_reg) & ~frame_data) == 8'h00;
    sequence s_take;
        frame_valid && RX_ENABLE_IN && !rx_done_flag;
    endsequence
    chk_take_loads: assert property (s_take ##0 (!ADDR_FILTER_EN_IN ||
        (frame_ninth && (given || bcast))) |=> rx_done_flag &&
        serial_buffer == $past(frame_data) && rx_ninth_bit == $past(frame_ninth))
        else $error("accepted frame not loaded");
    chk_given_hit: assert property (s_take ##0 (ADDR_FILTER_EN_IN && frame_ninth && given)
        |=> rx_done_flag) else $error("given address missed");
    chk_bcast_hit: assert property (s_take ##0 (ADDR_FILTER_EN_IN && frame_ninth && bcast)
        |=> rx_done_flag) else $error("broadcast address missed");
    chk_miss_quiet: assert property (s_take ##0 (ADDR_FILTER_EN_IN &&
        !(frame_ninth && (given || bcast))) |=> !rx_done_flag) else $error("flag on miss");
    chk_off_quiet: assert property (!RX_ENABLE_IN && !rx_done_flag |=> !rx_done_flag)
        else $error("flag while receive off");
    chk_flag_holds: assert property (rx_done_flag && !rx_done_clr |=>
        rx_done_flag && $stable(serial_buffer)) else $error("flag or buffer moved");
    chk_addr_read: assert property (reg_addr == 8'ha9 |-> reg_rdata == addr_reg)
        else $error("address register read wrong");
    chk_mask_read: assert property (reg_addr == 8'hb9 |-> reg_rdata == mask_reg)
        else $error("mask register read wrong");
endmodule // umam_chk
`default_nettype wire

/* File: test/umam_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module umam_tb;
    import umam_pkg::*;
    logic clk, rst_n, cyc, stb, we, fv, fn, irq, ren, filt, ack, n, h, exp_nine;
    logic [7:0] adr, fd, d, exp_buf;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    int n_fail, n_compared, seed, n_drop;
    logic drop;
    logic [8:0] exp_q[$];
    int modes[4] = '{3, 7, 1, 0};
    umam_if link_if();
    umam_ctrl u_umam_ctrl (.CORE_CLK_IN(clk), .ARST_N_IN(rst_n), .WB_CYC_IN(cyc),
        .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
        .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .FRAME_VALID_IN(fv), .FRAME_DATA_IN(fd),
        .FRAME_NINTH_IN(fn), .IRQ_OUT(irq), .RX_ENABLE_OUT(ren), .ADDR_FILTER_EN_OUT(filt),
        .LINK(link_if.ctrl));
    umam_device u_umam_device (.CORE_CLK_IN(clk), .ARST_N_IN(rst_n), .LINK(link_if.device),
        .RX_ENABLE_IN(ren), .ADDR_FILTER_EN_IN(filt), .FRAME_DROP_OUT(drop));
    umam_chk u_umam_chk (.CORE_CLK_IN(clk), .ARST_N_IN(rst_n), .RX_ENABLE_IN(ren),
        .ADDR_FILTER_EN_IN(filt), .frame_valid(link_if.frame_valid),
        .frame_data(link_if.frame_data), .frame_ninth(link_if.frame_ninth),
        .reg_wr(link_if.reg_wr), .reg_addr(link_if.reg_addr), .reg_wdata(link_if.reg_wdata),
        .reg_rdata(link_if.reg_rdata), .rx_done_flag(link_if.rx_done_flag),
        .rx_done_clr(link_if.rx_done_clr), .serial_buffer(link_if.serial_buffer),
        .rx_ninth_bit(link_if.rx_ninth_bit));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Master waits on ack with no assumed latency; only the watchdog ends a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dat);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= dat;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic frame(input logic [7:0] dat, input logic nb);
        @(posedge clk);
        fv <= 1'b1;
        fd <= dat;
        fn <= nb;
        @(posedge clk);
        fv <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // Model of acceptance: receive on, then filter off or ninth bit with a match
    function automatic logic hit(int c, int a, int m, int b, logic nb);
        return c[0] && (!c[1] || (nb && (((b ^ a) & m) == 0 || ((a | m) & ~b) == 0)));
    endfunction
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Lost-frame pulse stands one cycle, so it is counted edge by edge
    always @(posedge clk) begin
        if (drop === 1'b1)
            n_drop++;
    end
    initial begin
        #40000;
        n_fail++;
        finish_test();
    end
    initial begin
        {rst_n, cyc, stb, we, fv, fn, adr, fd, wdat} = '0;
        sel = 4'h1;
        n_fail = 0;
        n_compared = 0;
        n_drop = 0;
        seed = 81276;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, UMAM_WB_CTRL_OFS, 32'h0);
        check(q, 32'h1);
        wb(1'b0, UMAM_WB_SLV_ADDR_OFS, 32'h0);
        check(q, 32'h0);
        wb(1'b0, UMAM_WB_SMASK_OFS, 32'h0);
        check(q, 32'h0);
        wb(1'b0, 8'h40, 32'h0);
        check(q, 32'h0);
        wb(1'b1, UMAM_WB_MASK_OFS, 32'h3);
        frame(8'h5a, 1'b0);
        check(irq, 1'b1);
        frame(8'h33, 1'b1);
        check(n_drop, 32'h1);
        wb(1'b0, UMAM_WB_STAT_OFS, 32'h0);
        check(q, 32'h3);
        wb(1'b0, UMAM_WB_RXDATA_OFS, 32'h0);
        check(q, 32'h25a);
        exp_buf = 8'h5a;
        exp_nine = 1'b0;
        wb(1'b1, UMAM_WB_SLV_ADDR_OFS, 32'ha4);
        wb(1'b1, UMAM_WB_SMASK_OFS, 32'hfa);
        wb(1'b0, UMAM_WB_SMASK_OFS, 32'h0);
        check(q, 32'hfa);
        for (int i = 0; i < 64; i++) begin
            wb(1'b1, UMAM_WB_STAT_OFS, 32'h3);
            wb(1'b1, UMAM_WB_CTRL_OFS, 32'(modes[i % 4]));
            d = 8'($random(seed));
            n = d[3] | i[2];
            // Bias toward the given address in modes 7 and 0, and the broadcast one in mode 0 only, with receive off
            if (i[0])
                d = (d & 8'h05) | 8'ha0;
            if (i % 8 == 7)
                d = d | 8'hfe;
            frame(d, n);
            h = hit(modes[i % 4], 8'ha4, 8'hfa, d, n);
            if (h)
                exp_q.push_back({n, d});
            check(irq, h);
            if (exp_q.size() > 0)
                {exp_nine, exp_buf} = exp_q.pop_front();
            wb(1'b0, UMAM_WB_RXDATA_OFS, 32'h0);
            check(q, {22'h0, h, exp_nine, exp_buf});
        end
        check(n_drop, 32'h1);
        // Addressed exchange: filter on while awaiting the address, off for the data after it
        wb(1'b1, UMAM_WB_STAT_OFS, 32'h3);
        wb(1'b1, UMAM_WB_CTRL_OFS, 32'h3);
        frame(8'h11, 1'b0);
        check(irq, 1'b0);
        frame(8'ha3, 1'b1);
        check(irq, 1'b0);
        frame(8'ha0, 1'b1);
        check(irq, 1'b1);
        wb(1'b0, UMAM_WB_RXDATA_OFS, 32'h0);
        check(q, 32'h3a0);
        wb(1'b1, UMAM_WB_CTRL_OFS, 32'h1);
        frame(8'h5c, 1'b0);
        wb(1'b0, UMAM_WB_RXDATA_OFS, 32'h0);
        check(q, 32'h25c);
        // Second reset in mid-run brings the address pair back to zero
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        sel <= 4'h0;
        wb(1'b1, UMAM_WB_SLV_ADDR_OFS, 32'h55);
        sel <= 4'h1;
        wb(1'b0, UMAM_WB_SLV_ADDR_OFS, 32'h0);
        check(q, 32'h0);
        wb(1'b0, UMAM_WB_SMASK_OFS, 32'h0);
        check(q, 32'h0);
        wb(1'b0, UMAM_WB_CTRL_OFS, 32'h0);
        check(q, 32'h1);
        finish_test();
    end
endmodule // umam_tb
`default_nettype wire
